//--- common/flc_map.svh
`ifndef FLC_MAP_SVH
`define FLC_MAP_SVH

// ********************
// Register offsets
// ********************
`define FLC_OFS_CTRL        8'h00
`define FLC_OFS_ADDR        8'h04
`define FLC_OFS_STATUS      8'h08
`define FLC_OFS_DATA        8'h0c

// ********************
// Control fields
// ********************
`define FLC_CTRL_OP_LSB     0
`define FLC_CTRL_OP_MSB     2
`define FLC_CTRL_GO         3
`define FLC_CTRL_HV         4

// ********************
// Status fields
// ********************
`define FLC_ST_BUSY         8
`define FLC_ST_SUSP         9
`define FLC_ST_REFUSED      10
`define FLC_ST_RB           11
`define FLC_ST_HV           12

// ********************
// Device status bits
// ********************
`define FLC_SR_READY        7
`define FLC_SR_ERASE_ERR    5
`define FLC_SR_WRITE_ERR    4
`define FLC_SR_SUPPLY_ERR   3
`define FLC_SR_SUSPENDED    2
`define FLC_SR_PROTECT_ERR  1

// ********************
// Reset values
// ********************
`define FLC_RST_SR          8'h80
`define FLC_RST_ADDR        32'h0

// ********************
// Timing
// ********************
`define FLC_CLK_NS          20
`define FLC_T_PULSE_NS      50
`define FLC_T_ACC_NS        120
`define FLC_SYNC_CYC        3
`define FLC_PULSE_CYC       ((`FLC_T_PULSE_NS + `FLC_CLK_NS - 1) / `FLC_CLK_NS)
`define FLC_ACC_CYC         ((`FLC_T_ACC_NS + `FLC_CLK_NS - 1) / `FLC_CLK_NS + `FLC_SYNC_CYC)

`endif

//--- common/flc_pkg.sv
package flc_pkg;

    // ********************
    // Operations ordered by software
    // ********************
    typedef enum logic [2:0] {
        OP_RD_STATUS,
        OP_CLR_STATUS,
        OP_SUSPEND,
        OP_RESUME,
        OP_SET_BLOCK,
        OP_SET_MASTER,
        OP_CLR_LOCKS,
        OP_RD_ARRAY
    } flc_op_e;

    // ********************
    // Sequencer states
    // ********************
    typedef enum logic [2:0] {
        S_IDLE,
        S_WR,
        S_WR_END,
        S_RD,
        S_RD_END
    } flc_st_e;

    typedef logic [7:0] flc_byte_t;

endpackage : flc_pkg

//--- src/flc_ctrl.sv
// Notes on behaviour
// [R1] Device halts program at an algorithm point
// [R2] Suspended: ready and suspended bits, pin high
// [R3] After suspend, reads return status
// [R4] Only read array, status, resume while suspended
// [R5] Resume continues program, clears both bits
// [R6] After resume, reads return status
// [R7] Keep reset pin level while suspended
// [R8] Block locks gate program; master gates locks
// [R9] Block lock needs master clear or high voltage
// [R10] Master lock needs high voltage on reset pin
// [R11] Lock is setup then confirm at address
// [R12] Lock runs, completion via ready bit and pin
// [R13] Bad lock sequence sets erase and write errors
// [R14] Clear locks clears all blocks at once
// [R15] Clear locks fails under master lock, no override; the bench flash model clears them with high voltage
// [R16] Clear locks at low supply sets supply error
// [R17] Bad clear sequence sets write and erase errors
// [R18] Status mode stays after clear locks
// [R19] Aborted clear leaves locks undefined; repeat it
// [R20] Master lock can never be cleared
// [R21] Locked block refused unless high voltage
// [R22] Check erase error after clear, then clear status
// [R23] Bit two reports write suspended
// [R24] Error bits cleared only by clear status
// [R25] Command codes are configurable constants
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`include "flc_map.svh"

module flc_ctrl
    import flc_pkg::*;
#(
    parameter int        ADDR_W       = 20,
    parameter flc_byte_t CODE_RD_ST   = 8'h70,
    parameter flc_byte_t CODE_CLR_ST  = 8'h50,
    parameter flc_byte_t CODE_RD_ARR  = 8'hff,
    parameter flc_byte_t CODE_SUSPEND = 8'hb0,
    parameter flc_byte_t CODE_RESUME  = 8'hd0,
    parameter flc_byte_t CODE_LOCK    = 8'h60,
    parameter flc_byte_t CODE_BLK_CNF = 8'h01,
    parameter flc_byte_t CODE_MST_CNF = 8'hf1,
    parameter flc_byte_t CODE_CLR_CNF = 8'hd0
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Flash pins
    output logic      [ADDR_W-1:0] fl_addr,
    output logic      [7:0]        fl_dq_out,
    output logic                   fl_dq_oe,
    input  wire logic [7:0]        fl_dq_in,
    output logic                   fl_ce_n,
    output logic                   fl_oe_n,
    output logic                   fl_we_n,
    output logic                   fl_rp_n,
    output logic                   fl_rp_hv,
    input  wire logic              ready_busy_out
);

    localparam logic [7:0] PULSE_CYC = 8'(`FLC_PULSE_CYC);
    localparam logic [7:0] ACC_CYC   = 8'(`FLC_ACC_CYC);

    if (ADDR_W < 1 || ADDR_W > 32) begin : g_chk
        $error("flc_ctrl: ADDR_W must lie in 1..32");
    end

    // ********************
    // Pin synchronisers
    // ********************
    logic [7:0] dq_sync;
    logic       rb_sync;

    flc_sync #(.W(8)) u_dq_sync (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .pin_in (fl_dq_in),
        .value  (dq_sync)
    );

    flc_sync #(.W(1)) u_rb_sync (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .pin_in (ready_busy_out),
        .value  (rb_sync)
    );

    // ********************
    // Command code per step
    // ********************
    function automatic flc_byte_t code_of(input flc_op_e op, input logic [1:0] step);
        flc_byte_t c;
        c = CODE_CLR_ST;
        if (step == 2'd0) begin
            unique case (op)
                OP_RD_STATUS:  c = CODE_RD_ST;
                OP_CLR_STATUS: c = CODE_CLR_ST;
                OP_SUSPEND:    c = CODE_SUSPEND;
                OP_RESUME:     c = CODE_RESUME;
                OP_RD_ARRAY:   c = CODE_RD_ARR;
                OP_SET_BLOCK,
                OP_SET_MASTER,
                OP_CLR_LOCKS:  c = CODE_LOCK;
            endcase
        end else if (step == 2'd1) begin
            unique case (op)
                OP_SET_BLOCK:  c = CODE_BLK_CNF;
                OP_SET_MASTER: c = CODE_MST_CNF;
                OP_CLR_LOCKS:  c = CODE_CLR_CNF;
                default:       c = CODE_CLR_ST;
            endcase
        end
        return c;
    endfunction : code_of

    // ********************
    // State
    // ********************
    logic              pready_ff,  nxt_pready;
    logic              pslverr_ff, nxt_pslverr;
    logic [31:0]       prdata_ff,  nxt_prdata;
    flc_op_e           op_ff,      nxt_op;
    logic [ADDR_W-1:0] addr_ff,    nxt_addr;
    logic              hv_ff,      nxt_hv;
    logic              refused_ff, nxt_refused;
    logic              busy_ff,    nxt_busy;
    logic              susp_ff,    nxt_susp;
    flc_byte_t         sr_ff,      nxt_sr;
    flc_byte_t         data_ff,    nxt_data;
    flc_st_e           st_ff,      nxt_st;
    logic [1:0]        step_ff,    nxt_step;
    logic [7:0]        cnt_ff,     nxt_cnt;
    flc_byte_t         dq_out_ff,  nxt_dq_out;
    logic              dq_oe_ff,   nxt_dq_oe;
    logic              ce_n_ff,    nxt_ce_n;
    logic              oe_n_ff,    nxt_oe_n;
    logic              we_n_ff,    nxt_we_n;
    logic              rp_n_ff;

    logic    access;
    logic    two_cycle;
    logic    polled;
    logic    wants_read;
    logic    allowed;
    flc_op_e wr_op;

    always_comb begin
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata  = 32'h0;
        nxt_op      = op_ff;
        nxt_addr    = addr_ff;
        nxt_hv      = hv_ff;
        nxt_refused = refused_ff;
        nxt_busy    = busy_ff;
        nxt_susp    = susp_ff;
        nxt_sr      = sr_ff;
        nxt_data    = data_ff;
        nxt_st      = st_ff;
        nxt_step    = step_ff;
        nxt_cnt     = cnt_ff;
        nxt_dq_out  = dq_out_ff;
        nxt_dq_oe   = dq_oe_ff;
        nxt_ce_n    = ce_n_ff;
        nxt_oe_n    = oe_n_ff;
        nxt_we_n    = we_n_ff;

        wr_op      = flc_op_e'(pwdata[`FLC_CTRL_OP_MSB:`FLC_CTRL_OP_LSB]);
        two_cycle  = (op_ff == OP_SET_BLOCK) || (op_ff == OP_SET_MASTER)
                     || (op_ff == OP_CLR_LOCKS); // [R11]
        polled     = two_cycle || (op_ff == OP_SUSPEND);
        wants_read = polled || (op_ff == OP_RD_STATUS) || (op_ff == OP_RD_ARRAY);
        // Suspended device takes only read array, read status and resume
        allowed    = !susp_ff || (wr_op == OP_RD_STATUS) || (wr_op == OP_RD_ARRAY)
                     || (wr_op == OP_RESUME); // [R4]

        // APB access, answered one cycle into the access phase
        access = psel && penable && !pready_ff;
        if (access) begin
            nxt_pready = 1'b1;
            unique case (paddr)
                `FLC_OFS_CTRL: begin
                    nxt_prdata = {27'h0, hv_ff, 1'b0, op_ff};
                    if (pwrite) begin
                        // Reset pin level kept while busy or suspended
                        if (!busy_ff && !susp_ff) begin
                            nxt_hv = pwdata[`FLC_CTRL_HV]; // [R7] [R19]
                        end
                        if (pwdata[`FLC_CTRL_GO]) begin
                            if (busy_ff || !allowed) begin
                                nxt_refused = 1'b1; // [R4]
                            end else begin
                                nxt_refused = 1'b0;
                                nxt_op      = wr_op;
                                nxt_busy    = 1'b1;
                                nxt_step    = 2'd0;
                                nxt_cnt     = 8'h0;
                                nxt_st      = S_WR;
                            end
                        end
                    end
                end
                `FLC_OFS_ADDR: begin
                    nxt_prdata = 32'(addr_ff);
                    if (pwrite && !busy_ff) begin
                        nxt_addr = pwdata[ADDR_W-1:0];
                    end
                end
                `FLC_OFS_STATUS: begin
                    nxt_prdata = 32'h0;
                    nxt_prdata[7:0]             = sr_ff; // [R23]
                    nxt_prdata[`FLC_ST_BUSY]    = busy_ff;
                    nxt_prdata[`FLC_ST_SUSP]    = susp_ff;
                    nxt_prdata[`FLC_ST_REFUSED] = refused_ff;
                    nxt_prdata[`FLC_ST_RB]      = rb_sync;
                    nxt_prdata[`FLC_ST_HV]      = hv_ff;
                end
                `FLC_OFS_DATA: begin
                    nxt_prdata = {24'h0, data_ff};
                end
                default: begin
                    nxt_pslverr = 1'b1;
                end
            endcase
        end

        // ********************
        // Flash sequencer
        // ********************
        unique case (st_ff)
            S_IDLE: begin
                nxt_ce_n  = 1'b1;
                nxt_oe_n  = 1'b1;
                nxt_we_n  = 1'b1;
                nxt_dq_oe = 1'b0;
            end
            S_WR: begin
                nxt_ce_n   = 1'b0;
                nxt_we_n   = 1'b0;
                nxt_dq_oe  = 1'b1;
                nxt_dq_out = code_of(op_ff, step_ff); // [R25]
                nxt_cnt    = cnt_ff + 8'h1;
                if (cnt_ff == PULSE_CYC) begin
                    nxt_we_n = 1'b1;
                    nxt_cnt  = 8'h0;
                    nxt_st   = S_WR_END;
                end
            end
            S_WR_END: begin
                nxt_cnt = cnt_ff + 8'h1;
                if (cnt_ff == 8'h0) begin
                    nxt_ce_n  = 1'b1;
                    nxt_dq_oe = 1'b0;
                end
                if (cnt_ff == PULSE_CYC - 8'h1) begin
                    nxt_cnt = 8'h0;
                    if (op_ff == OP_RESUME) begin
                        nxt_susp = 1'b0; // [R5]
                    end
                    if (step_ff == 2'd0 && two_cycle) begin
                        nxt_step = 2'd1; // [R11]
                        nxt_st   = S_WR;
                    end else if (step_ff != 2'd2 && wants_read) begin
                        nxt_st = S_RD; // [R3] [R12]
                    end else begin
                        nxt_busy = 1'b0;
                        nxt_st   = S_IDLE;
                    end
                end
            end
            S_RD: begin
                nxt_ce_n = 1'b0;
                nxt_oe_n = 1'b0;
                nxt_cnt  = cnt_ff + 8'h1;
                if (cnt_ff == ACC_CYC) begin
                    nxt_cnt  = 8'h0;
                    nxt_oe_n = 1'b1;
                    nxt_ce_n = 1'b1;
                    if (op_ff == OP_RD_ARRAY) begin
                        nxt_data = dq_sync;
                    end else begin
                        nxt_sr = dq_sync;
                    end
                    nxt_st = S_RD_END;
                end
            end
            S_RD_END: begin
                // Status latch refreshes only on a fresh output-enable edge
                nxt_cnt = cnt_ff + 8'h1;
                if (cnt_ff == PULSE_CYC - 8'h1) begin
                    nxt_cnt = 8'h0;
                    if (polled && !sr_ff[`FLC_SR_READY]) begin
                        nxt_st = S_RD; // [R1] [R12]
                    end else if (op_ff == OP_CLR_LOCKS && sr_ff[`FLC_SR_ERASE_ERR]) begin
                        nxt_step = 2'd2; // [R22] [R15] [R16] [R17]
                        nxt_st   = S_WR;
                    end else begin
                        if (op_ff == OP_SUSPEND) begin
                            nxt_susp = sr_ff[`FLC_SR_READY]
                                       && sr_ff[`FLC_SR_SUSPENDED]; // [R2] [R23]
                        end
                        nxt_busy = 1'b0;
                        nxt_st   = S_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
            op_ff      <= OP_RD_STATUS;
            addr_ff    <= ADDR_W'(`FLC_RST_ADDR);
            hv_ff      <= 1'b0;
            refused_ff <= 1'b0;
            busy_ff    <= 1'b0;
            susp_ff    <= 1'b0;
            sr_ff      <= `FLC_RST_SR;
            data_ff    <= 8'h0;
            st_ff      <= S_IDLE;
            step_ff    <= 2'd0;
            cnt_ff     <= 8'h0;
            dq_out_ff  <= 8'h0;
            dq_oe_ff   <= 1'b0;
            ce_n_ff    <= 1'b1;
            oe_n_ff    <= 1'b1;
            we_n_ff    <= 1'b1;
            rp_n_ff    <= 1'b0;
        end else if (clk_en) begin
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
            op_ff      <= nxt_op;
            addr_ff    <= nxt_addr;
            hv_ff      <= nxt_hv;
            refused_ff <= nxt_refused;
            busy_ff    <= nxt_busy;
            susp_ff    <= nxt_susp;
            sr_ff      <= nxt_sr;
            data_ff    <= nxt_data;
            st_ff      <= nxt_st;
            step_ff    <= nxt_step;
            cnt_ff     <= nxt_cnt;
            dq_out_ff  <= nxt_dq_out;
            dq_oe_ff   <= nxt_dq_oe;
            ce_n_ff    <= nxt_ce_n;
            oe_n_ff    <= nxt_oe_n;
            we_n_ff    <= nxt_we_n;
            rp_n_ff    <= 1'b1;
        end
    end

    // ********************
    // Outputs
    // ********************
    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign fl_addr   = addr_ff;
    assign fl_dq_out = dq_out_ff;
    assign fl_dq_oe  = dq_oe_ff;
    assign fl_ce_n   = ce_n_ff;
    assign fl_oe_n   = oe_n_ff;
    assign fl_we_n   = we_n_ff;
    assign fl_rp_n   = rp_n_ff;
    assign fl_rp_hv  = hv_ff; // [R9] [R10] [R21]

endmodule : flc_ctrl

//--- src/flc_sync.sv
module flc_sync
    import flc_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    // Pin side
    input  wire logic [W-1:0] pin_in,
    // Filtered value
    output logic      [W-1:0] value
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] out_ff;
    logic [W-1:0] nxt_out;

    if (W < 1) begin : g_chk
        $error("flc_sync: width must be at least one");
    end

    // A change is taken only once stages two and three agree
    always_comb begin
        nxt_out = (s2_ff == s3_ff) ? s3_ff : out_ff;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            out_ff <= '0;
        end else if (clk_en) begin
            s1_ff  <= pin_in;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign value = out_ff;

endmodule : flc_sync

//--- tb/flc_checker.sv
// ********************
// Port checker
// ********************
module flc_checker #(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              clk_en,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    input wire logic              pslverr,
    // Flash pins
    input wire logic [ADDR_W-1:0] fl_addr,
    input wire logic              fl_dq_oe,
    input wire logic              fl_ce_n,
    input wire logic              fl_oe_n,
    input wire logic              fl_we_n,
    input wire logic              fl_rp_n,
    input wire logic              fl_rp_hv
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_ready_one_wait: assert property (psel && penable && !pready && clk_en |=> pready)
        else $error("late pready");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("long pready");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("lone pslverr");
    a_drive_selected: assert property (fl_dq_oe |-> !fl_ce_n && fl_oe_n)
        else $error("stray data drive");
    a_we_pulse_len: assert property ($fell(fl_we_n) |-> !fl_we_n [*3] ##1 fl_we_n)
        else $error("bad write strobe");
    a_read_len: assert property ($fell(fl_oe_n) |->
        (!fl_oe_n && !fl_ce_n) [*8] ##1 !fl_oe_n ##1 fl_oe_n)
        else $error("bad read strobe");
    a_ce_gap: assert property ($rose(fl_ce_n) |-> fl_ce_n [*2])
        else $error("short select gap");
    a_addr_held: assert property (!fl_ce_n |=> $stable(fl_addr))
        else $error("address moved");
    a_hv_held: assert property (!fl_ce_n |=> $stable(fl_rp_hv))
        else $error("high voltage moved");
    a_rp_kept: assert property (fl_rp_n |=> fl_rp_n)
        else $error("reset pin dropped");
endmodule : flc_checker

bind flc_ctrl flc_checker #(.ADDR_W(ADDR_W)) u_chk (.clock, .rst_n, .clk_en, .psel,
    .penable, .pready, .pslverr, .fl_addr, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n,
    .fl_rp_n, .fl_rp_hv);

//--- tb/flc_flash_model.sv
// ********************
// Behavioural flash device
// ********************
module flc_flash_model
    import flc_pkg::*;
#(
    parameter int LAT  = 20,
    parameter int PLAT = 300
) (
    // Clock
    input  wire logic        clock,
    // Controller side
    input  wire logic [19:0] fl_addr,
    input  wire logic [7:0]  fl_dq_out,
    input  wire logic        fl_ce_n,
    input  wire logic        fl_oe_n,
    input  wire logic        fl_we_n,
    input  wire logic        fl_rp_n,
    input  wire logic        fl_rp_hv,
    // Bench controls
    input  wire logic        vpp_low,
    input  wire logic        prog_go,
    // Back to controller
    output logic      [7:0]  fl_dq_in,
    output logic             ready_busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    flc_byte_t   sr = 8'h80;
    flc_byte_t   cmd, kind;
    flc_byte_t   setup = 8'h00;
    flc_byte_t   rd;
    logic [15:0] locks = '0;
    logic        master = 1'b0, stmode = 1'b0, we_q = 1'b1, sreq = 1'b0;
    logic [3:0]  blk;
    int          cnt = 0;

    // Released bus shows the inverse so a stale byte cannot pass
    assign rd = stmode ? sr : {locks[fl_addr[19:16]], fl_addr[6:0]};
    assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd : ~rd;
    assign ready_busy_out = sr[7];

    always @(posedge clock) begin
        if (!fl_rp_n) begin
            if (kind == 8'hd0 && !sr[7]) locks = ~locks;
            sr = 8'h80;
            stmode = 1'b0;
            setup = 8'h00;
            sreq = 1'b0;
        end else begin
            if (!fl_we_n) cmd = fl_dq_out;
            if (fl_we_n && !we_q && !fl_ce_n) begin
                if (setup == 8'h60) begin
                    setup = 8'h00;
                    stmode = 1'b1;
                    if (cmd inside {8'h01, 8'hf1, 8'hd0}) begin
                        kind = cmd;
                        blk = fl_addr[19:16];
                        cnt = LAT;
                        sr[7] = 1'b0;
                    end else sr = sr | 8'h30;
                end else case (cmd)
                    8'h60: setup = cmd;
                    8'h70: stmode = 1'b1;
                    8'hff: stmode = 1'b0;
                    8'h50: sr = sr & 8'hc5;
                    8'hb0: begin
                        stmode = 1'b1;
                        sreq = !sr[7];
                    end
                    8'hd0: begin
                        stmode = 1'b1;
                        if (sr[2]) sr = sr & 8'h7b;
                    end
                    default: ;
                endcase
            end
            if (prog_go && sr[7]) begin
                kind = 8'h40;
                blk = fl_addr[19:16];
                cnt = PLAT;
                sr[7] = 1'b0;
            end
            // Suspend lands only on an algorithm step boundary
            if (sreq && cnt[2:0] == 3'd0) begin
                sreq = 1'b0;
                sr = sr | 8'h84;
            end else if (!sr[7] && !sr[2]) begin
                if (cnt > 0) cnt--;
                else begin
                    sr[7] = 1'b1;
                    case (kind)
                        8'h01: if (master && !fl_rp_hv) sr = sr | 8'h12;
                               else locks[blk] = 1'b1;
                        8'hf1: if (!fl_rp_hv) sr = sr | 8'h12;
                               else master = 1'b1;
                        8'hd0: if (vpp_low) sr = sr | 8'h28;
                               else if (master && !fl_rp_hv) sr = sr | 8'h22;
                               else locks = '0;
                        default: if (locks[blk] && !fl_rp_hv) sr = sr | 8'h12;
                    endcase
                end
            end
        end
        we_q = fl_we_n;
    end
endmodule : flc_flash_model

//--- tb/tb.sv
`include "flc_map.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        vpp_low = 1'b0, prog_go = 1'b0, pready, pslverr, rerr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [19:0] fl_addr;
    logic [7:0]  fl_dq_out, fl_dq_in;
    logic        fl_ce_n, fl_oe_n, fl_we_n, fl_rp_n, fl_rp_hv, ready_busy_out;
    int          fail_count = 0, total_checks = 0, cycles = 0;

    always #10 clock = ~clock;

    flc_ctrl u_dut (.clock, .rst_n, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .fl_addr, .fl_dq_out, .fl_dq_oe(),
        .fl_dq_in, .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_rp_n, .fl_rp_hv, .ready_busy_out);
    flc_flash_model u_flash (.clock, .fl_addr, .fl_dq_out, .fl_ce_n, .fl_oe_n, .fl_we_n,
        .fl_rp_n, .fl_rp_hv, .vpp_low, .prog_go, .fl_dq_in, .ready_busy_out);

    // ********************
    // Bus tasks
    // ********************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Request held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic op(input logic [2:0] o, input logic hv);
        apb(1'b1, `FLC_OFS_CTRL, {27'h0, hv, 1'b1, o});
        do apb(1'b0, `FLC_OFS_STATUS, 32'h0); while (rdat[`FLC_ST_BUSY] === 1'b1);
    endtask : op

    task automatic sr_op(input string nm, input logic [2:0] o, input logic hv,
                         input logic [7:0] e);
        op(o, hv);
        chk(nm, {24'h0, rdat[7:0]}, {24'h0, e});
    endtask : sr_op

    task automatic arr(input logic [31:0] a, input logic [7:0] e);
        apb(1'b1, `FLC_OFS_ADDR, a);
        op(3'd7, 1'b0);
        apb(1'b0, `FLC_OFS_DATA, 32'h0);
        chk("array byte", {24'h0, rdat[7:0]}, {24'h0, e});
    endtask : arr

    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            end_of_test();
        end
    end

    // ********************
    // Tests
    // ********************
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        apb(1'b0, `FLC_OFS_STATUS, 32'h0);
        chk("status reset", {19'h0, rdat[12:0]}, 32'h0880);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", {31'h0, rerr}, 32'h1);
        apb(1'b1, `FLC_OFS_ADDR, 32'h20000);
        apb(1'b0, `FLC_OFS_ADDR, 32'h0);
        chk("addr", rdat, 32'h20000);
        $display("test registers done");
        sr_op("lock block", 3'd4, 1'b0, 8'h80);
        arr(32'h20000, 8'h80);
        sr_op("master low", 3'd5, 1'b0, 8'h92);
        op(3'd1, 1'b0);
        sr_op("after clear", 3'd0, 1'b0, 8'h80);
        sr_op("master high", 3'd5, 1'b1, 8'h80);
        chk("hv shown", {31'h0, rdat[`FLC_ST_HV]}, 32'h1);
        apb(1'b1, `FLC_OFS_ADDR, 32'h30000);
        sr_op("block master", 3'd4, 1'b0, 8'h92);
        op(3'd1, 1'b0);
        sr_op("block high", 3'd4, 1'b1, 8'h80);
        $display("test set locks done");
        sr_op("clear master", 3'd6, 1'b0, 8'ha2);
        sr_op("auto clear", 3'd0, 1'b0, 8'h80);
        arr(32'h30000, 8'h80);
        vpp_low <= 1'b1;
        sr_op("clear supply", 3'd6, 1'b1, 8'ha8);
        vpp_low <= 1'b0;
        sr_op("clear high", 3'd6, 1'b1, 8'h80);
        arr(32'h30000, 8'h00);
        arr(32'h20000, 8'h00);
        sr_op("master kept", 3'd4, 1'b0, 8'h92);
        op(3'd1, 1'b0);
        $display("test clear locks done");
        apb(1'b1, `FLC_OFS_ADDR, 32'h50000);
        prog_go <= 1'b1;
        @(posedge clock);
        prog_go <= 1'b0;
        op(3'd2, 1'b0);
        chk("suspend", {19'h0, rdat[12:0]}, 32'h0a84);
        op(3'd4, 1'b0);
        chk("refused", {30'h0, rdat[10:9]}, 32'h3);
        arr(32'h60000, 8'h00);
        apb(1'b0, `FLC_OFS_STATUS, 32'h0);
        chk("accepted", {30'h0, rdat[10:9]}, 32'h1);
        op(3'd3, 1'b0);
        sr_op("resumed", 3'd0, 1'b0, 8'h00);
        chk("not suspended", {31'h0, rdat[`FLC_ST_SUSP]}, 32'h0);
        for (int i = 0; i < 40 && rdat[7] !== 1'b1; i++) op(3'd0, 1'b0);
        chk("program end", {24'h0, rdat[7:0]}, 32'h80);
        $display("test suspend done");
        end_of_test();
    end
endmodule : tb
